// ---- logic/pdl_port_bank.sv ----
/*
 Direction and output-latch register bank for fourteen port groups.
 Groups 0..11 are the main ports, reached by byte or single-bit accesses
 on the main register space; groups 12 and 13 are the secondary ports,
 reached only over the extended register interface.

 Group index, port, latch offset, direction offset, implemented
 direction bits, writable latch bits:
   index  0   port 1    ff01  ff21   df   9e
   index  1   port 2    ff02  ff22   ff   80
   index  2   port 3    ff03  ff23   0f   0f
   index  3   port 4    ff04  ff24   c3   c3
   index  4   port 8    ff08  ff28   0f   0f
   index  5   port 9    ff09  ff29   0f   0f
   index  6   port 10   ff0a  ff2a   0f   0f
   index  7   port 11   ff0b  ff2b   0f   0f
   index  8   port 12   ff0c  ff2c   01   01
   index  9   port 13   ff0d  ff2d   0f   0f
   index 10   port 14   ff0e  ff2e   0f   0f
   index 11   port 15   ff0f  ff2f   0f   0f
   index 12   second 0  8b    8c     3f   3f
   index 13   second 1  8e    8f     3f   3f
 Port 12 bits 1 and 2 have a fixed input direction: their latch bits
 ignore writes and read the pin level unless flagged as a clock input.

 Register behaviour:
   A direction bit of 0 drives the pin from its latch bit; 1 releases it.
   Missing direction bits read 1 and cannot be cleared.
   Missing latch bits read 0 and ignore writes.
   A latch read gives the pin level for input pins, the latch for output
   pins, and 0 for any pin flagged as a clock input.
   A single-bit write replaces one bit of the stored byte with wdata[0];
   it never copies pin levels of neighbouring input pins into the latch.
   Reset sets every direction byte to ff and every latch byte to 00.

 Bus answers:
   Both buses answer one cycle after the strobe with a one-cycle ack.
   Read data stands for that one cycle and is 00 otherwise.
   An unmapped address gives no ack, 00 data and changes nothing.
   Extended addresses are not decoded on the main bus and main
   addresses are not decoded on the extended bus.
   Back-to-back accesses are allowed; a read right after a write sees
   the new value.

 Pins:
   pin_out and pin_oe_n come straight from the latch and direction flops
   and change one edge after a write.
   Read data uses pin_in as sampled in the access cycle.

 Assumes:
   pin inputs, clock-input flags and access strobes are synchronous
   to mclk and already free of metastability;
   each strobe is a one-cycle pulse with its address and data stable;
   rstn is synchronous and active low;
   alternate functions and pull-ups are handled outside this block.
*/
`include "pdl_regs.svh"

module pdl_port_bank #(
   parameter int NG    = 14,
   parameter int NMAIN = 12
)(
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic [15:0]       cpu_addr,
   input  wire logic              cpu_wr,
   input  wire logic              cpu_rd,
   input  wire logic              cpu_bit,
   input  wire logic [2:0]        cpu_bitsel,
   input  wire logic [7:0]        cpu_wdata,
   output logic      [7:0]        cpu_rdata_ff,
   output logic                   cpu_ack_ff,
   input  wire logic [7:0]        ext_addr,
   input  wire logic              ext_wr,
   input  wire logic              ext_rd,
   input  wire logic [7:0]        ext_wdata,
   output logic      [7:0]        ext_rdata_ff,
   output logic                   ext_ack_ff,
   input  wire logic [NG*8-1:0]   pin_in,
   input  wire logic [NG*8-1:0]   clk_in_mode,
   output logic      [NG*8-1:0]   pin_out,
   output logic      [NG*8-1:0]   pin_oe_n
);

   // ==========================================
   // Address tables
   localparam logic [15:0] LAT_OFS [NMAIN] = '{
      `PDL_OFS_LAT1,
      `PDL_OFS_LAT2,
      `PDL_OFS_LAT3,
      `PDL_OFS_LAT4,
      `PDL_OFS_LAT8,
      `PDL_OFS_LAT9,
      `PDL_OFS_LAT10,
      `PDL_OFS_LAT11,
      `PDL_OFS_LAT12,
      `PDL_OFS_LAT13,
      `PDL_OFS_LAT14,
      `PDL_OFS_LAT15
   };
   localparam logic [15:0] DIR_OFS [NMAIN] = '{
      `PDL_OFS_DIR1,
      `PDL_OFS_DIR2,
      `PDL_OFS_DIR3,
      `PDL_OFS_DIR4,
      `PDL_OFS_DIR8,
      `PDL_OFS_DIR9,
      `PDL_OFS_DIR10,
      `PDL_OFS_DIR11,
      `PDL_OFS_DIR12,
      `PDL_OFS_DIR13,
      `PDL_OFS_DIR14,
      `PDL_OFS_DIR15
   };
   localparam logic [7:0] ELAT_OFS [2] = '{
      `PDL_OFS_ELAT0,
      `PDL_OFS_ELAT1
   };
   localparam logic [7:0] EDIR_OFS [2] = '{
      `PDL_OFS_EDIR0,
      `PDL_OFS_EDIR1
   };

   localparam logic [NG*8-1:0] DIR_MASK  = `PDL_DIR_MASK;
   localparam logic [NG*8-1:0] LATW_MASK = `PDL_LATW_MASK;
   localparam logic [NG*8-1:0] LATR_MASK = `PDL_LATR_MASK;

   // ==========================================
   // Access decode
   pdl_pkg::pdl_acc_t cpu_acc;
   wire logic         cpu_req;
   wire logic         ext_req;

   assign cpu_req = cpu_wr | cpu_rd;
   assign ext_req = ext_wr | ext_rd;
   assign cpu_acc = !cpu_req ? pdl_pkg::PDL_ACC_NONE :
                    cpu_bit  ? pdl_pkg::PDL_ACC_BIT  : pdl_pkg::PDL_ACC_BYTE;

   // Per-group state and decode
   pdl_pkg::pdl_byte_t lat_ff   [NG];
   pdl_pkg::pdl_byte_t dir_ff   [NG];
   pdl_pkg::pdl_byte_t nxt_lat  [NG];
   pdl_pkg::pdl_byte_t nxt_dir  [NG];
   pdl_pkg::pdl_byte_t rd_lat   [NG];
   logic               hit_lat  [NG];
   logic               hit_dir  [NG];
   logic               wr_lat   [NG];
   logic               wr_dir   [NG];
   logic               main_grp [NG];

   // Byte after a single-bit write to cur
   function automatic pdl_pkg::pdl_byte_t bit_merge(
      input pdl_pkg::pdl_byte_t cur,
      input logic [2:0]         sel,
      input logic               val
   );
      pdl_pkg::pdl_byte_t res;
      res      = cur;
      res[sel] = val;
      return res;
   endfunction

   // ==========================================
   // Group logic
   genvar g;
   generate
      for (g = 0; g < NG; g++)
      begin : grp
         wire pdl_pkg::pdl_byte_t dmask;
         wire pdl_pkg::pdl_byte_t wmask;
         wire pdl_pkg::pdl_byte_t rmask;
         wire pdl_pkg::pdl_byte_t lat_src;
         wire pdl_pkg::pdl_byte_t dir_src;
         wire pdl_pkg::pdl_byte_t pins;
         wire pdl_pkg::pdl_byte_t clkin;

         assign dmask = DIR_MASK[g*8 +: 8];
         assign wmask = LATW_MASK[g*8 +: 8];
         assign rmask = LATR_MASK[g*8 +: 8];
         assign pins  = pin_in[g*8 +: 8];
         assign clkin = clk_in_mode[g*8 +: 8];

         if (g < NMAIN)
         begin : main_dec
            assign hit_lat[g]  = (cpu_acc != pdl_pkg::PDL_ACC_NONE) &&
                                 (cpu_addr == LAT_OFS[g]);
            assign hit_dir[g]  = (cpu_acc != pdl_pkg::PDL_ACC_NONE) &&
                                 (cpu_addr == DIR_OFS[g]);
            assign wr_lat[g]   = hit_lat[g] & cpu_wr;
            assign wr_dir[g]   = hit_dir[g] & cpu_wr;
            assign main_grp[g] = 1'b1;
            assign lat_src = (cpu_acc == pdl_pkg::PDL_ACC_BIT) ?
                             bit_merge(lat_ff[g], cpu_bitsel, cpu_wdata[0]) : cpu_wdata;
            assign dir_src = (cpu_acc == pdl_pkg::PDL_ACC_BIT) ?
                             bit_merge(dir_ff[g], cpu_bitsel, cpu_wdata[0]) : cpu_wdata;
         end
         else
         begin : ext_dec
            assign hit_lat[g]  = ext_req && (ext_addr == ELAT_OFS[g-NMAIN]);
            assign hit_dir[g]  = ext_req && (ext_addr == EDIR_OFS[g-NMAIN]);
            assign wr_lat[g]   = hit_lat[g] & ext_wr;
            assign wr_dir[g]   = hit_dir[g] & ext_wr;
            assign main_grp[g] = 1'b0;
            assign lat_src     = ext_wdata;
            assign dir_src     = ext_wdata;
         end

         assign nxt_lat[g] = wr_lat[g] ? (lat_src & wmask) : lat_ff[g];
         assign nxt_dir[g] = wr_dir[g] ? (dir_src | ~dmask) : dir_ff[g];

         wire pdl_pkg::pdl_byte_t pin_view;
         wire pdl_pkg::pdl_byte_t lat_view;
         assign pin_view  = dir_ff[g] & pins;
         assign lat_view  = ~dir_ff[g] & lat_ff[g];
         // clock input reads 0, missing bits read 0
         assign rd_lat[g] = (pin_view | lat_view) & rmask & ~clkin;

         always_ff @(posedge mclk)
         begin
            if (!rstn)
            begin
               lat_ff[g] <= `PDL_RST_LAT;
               dir_ff[g] <= `PDL_RST_DIR;
            end
            else
            begin
               lat_ff[g] <= nxt_lat[g];
               dir_ff[g] <= nxt_dir[g];
            end
         end

      end
   endgenerate

   // ==========================================
   // Pin drive, straight from the latch and direction flops
   generate
      for (g = 0; g < NG; g++)
      begin : drv
         assign pin_out[g*8 +: 8]  = lat_ff[g];
         assign pin_oe_n[g*8 +: 8] = dir_ff[g];
      end
   endgenerate

   // ==========================================
   // Read data selection
   pdl_pkg::pdl_byte_t nxt_cpu_rdata;
   pdl_pkg::pdl_byte_t nxt_ext_rdata;
   logic               cpu_hit;
   logic               ext_hit;

   always_comb
   begin
      nxt_cpu_rdata = 8'h00;
      nxt_ext_rdata = 8'h00;
      cpu_hit       = 1'b0;
      ext_hit       = 1'b0;
      for (int i = 0; i < NG; i++)
      begin
         if (main_grp[i])
         begin
            if (hit_lat[i])
            begin
               nxt_cpu_rdata = nxt_cpu_rdata | rd_lat[i];
            end
            if (hit_dir[i])
            begin
               nxt_cpu_rdata = nxt_cpu_rdata | dir_ff[i];
            end
            cpu_hit = cpu_hit | hit_lat[i] | hit_dir[i];
         end
         else
         begin
            if (hit_lat[i])
            begin
               nxt_ext_rdata = nxt_ext_rdata | rd_lat[i];
            end
            if (hit_dir[i])
            begin
               nxt_ext_rdata = nxt_ext_rdata | dir_ff[i];
            end
            ext_hit = ext_hit | hit_lat[i] | hit_dir[i];
         end
      end
   end

   // Read data is only presented for reads, else 00
   pdl_pkg::pdl_byte_t cpu_rdata_sel;
   pdl_pkg::pdl_byte_t ext_rdata_sel;

   assign cpu_rdata_sel = cpu_rd ? nxt_cpu_rdata : 8'h00;
   assign ext_rdata_sel = ext_rd ? nxt_ext_rdata : 8'h00;

   // ==========================================
   // Answer registers
   // Unmapped addresses read 00 and give no acknowledge
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         cpu_rdata_ff <= 8'h00;
         cpu_ack_ff   <= 1'b0;
      end
      else
      begin
         cpu_rdata_ff <= cpu_rdata_sel;
         cpu_ack_ff   <= cpu_hit;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         ext_rdata_ff <= 8'h00;
         ext_ack_ff   <= 1'b0;
      end
      else
      begin
         ext_rdata_ff <= ext_rdata_sel;
         ext_ack_ff   <= ext_hit;
      end
   end

endmodule

// ---- common/pdl_regs.svh ----
/*
 Register offsets, implemented-bit masks and reset values of the port
 direction and output-latch bank.
 Assumes a 16-bit main register space and an 8-bit extended register space.
*/
`ifndef PDL_REGS_SVH
`define PDL_REGS_SVH
// ==========================================
// Main space offsets
`define PDL_OFS_LAT1  16'hff01
`define PDL_OFS_LAT2  16'hff02
`define PDL_OFS_LAT3  16'hff03
`define PDL_OFS_LAT4  16'hff04
`define PDL_OFS_LAT8  16'hff08
`define PDL_OFS_LAT9  16'hff09
`define PDL_OFS_LAT10 16'hff0a
`define PDL_OFS_LAT11 16'hff0b
`define PDL_OFS_LAT12 16'hff0c
`define PDL_OFS_LAT13 16'hff0d
`define PDL_OFS_LAT14 16'hff0e
`define PDL_OFS_LAT15 16'hff0f
`define PDL_OFS_DIR1  16'hff21
`define PDL_OFS_DIR2  16'hff22
`define PDL_OFS_DIR3  16'hff23
`define PDL_OFS_DIR4  16'hff24
`define PDL_OFS_DIR8  16'hff28
`define PDL_OFS_DIR9  16'hff29
`define PDL_OFS_DIR10 16'hff2a
`define PDL_OFS_DIR11 16'hff2b
`define PDL_OFS_DIR12 16'hff2c
`define PDL_OFS_DIR13 16'hff2d
`define PDL_OFS_DIR14 16'hff2e
`define PDL_OFS_DIR15 16'hff2f
// ==========================================
// Extended space offsets
`define PDL_OFS_ELAT0 8'h8b
`define PDL_OFS_EDIR0 8'h8c
`define PDL_OFS_ELAT1 8'h8e
`define PDL_OFS_EDIR1 8'h8f
// ==========================================
// Implemented bits, group 13 in the top byte down to group 0
`define PDL_DIR_MASK  112'h3f3f0f0f0f010f0f0f0fc30fffdf
`define PDL_LATW_MASK 112'h3f3f0f0f0f010f0f0f0fc30f809e
`define PDL_LATR_MASK 112'h3f3f0f0f0f070f0f0f0fc30f809e
// ==========================================
// Reset values
`define PDL_RST_DIR   8'hff
`define PDL_RST_LAT   8'h00
`endif

// ---- common/pdl_pkg.sv ----
/*
 Types shared by the port direction and latch bank.
 Assumes nothing beyond a SystemVerilog tool.
*/
package pdl_pkg;
   typedef logic [7:0] pdl_byte_t;
   // Kind of processor access on the main space
   typedef enum logic [2:0]
   {
      PDL_ACC_NONE = 3'h1,
      PDL_ACC_BYTE = 3'h2,
      PDL_ACC_BIT  = 3'h4
   } pdl_acc_t;
endpackage

// ---- sim/pdl_port_bank_chk.sv ----
/*
 Checker for the port bank, bound into every pdl_port_bank instance.
 Assumes mclk rising edge and synchronous active-low rstn.
*/
`include "pdl_regs.svh"
module pdl_port_bank_chk #(
   parameter int NG = 14
)(
   input wire logic [15:0]     cpu_addr,
   input wire logic            mclk,
   input wire logic            rstn,
   input wire logic            cpu_wr,
   input wire logic            cpu_rd,
   input wire logic            cpu_bit,
   input wire logic [2:0]      cpu_bitsel,
   input wire logic [7:0]      cpu_wdata,
   input wire logic [7:0]      cpu_rdata_ff,
   input wire logic            cpu_ack_ff,
   input wire logic [7:0]      ext_addr,
   input wire logic            ext_wr,
   input wire logic            ext_rd,
   input wire logic [7:0]      ext_wdata,
   input wire logic [7:0]      ext_rdata_ff,
   input wire logic            ext_ack_ff,
   input wire logic [NG*8-1:0] pin_in,
   input wire logic [NG*8-1:0] clk_in_mode,
   input wire logic [NG*8-1:0] pin_out,
   input wire logic [NG*8-1:0] pin_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // Access sequences
   sequence s_dir_wr;
      cpu_wr && !cpu_bit && cpu_addr == `PDL_OFS_DIR2;
   endsequence
   sequence s_elat_wr;
      ext_wr && ext_addr == `PDL_OFS_ELAT1;
   endsequence
   a_rst_dir_ones: assert property (disable iff (1'b0) !rstn |=> &pin_oe_n)
      else $error("direction not all ones after reset");
   a_rst_lat_zero: assert property (disable iff (1'b0) !rstn |=> pin_out == '0)
      else $error("latch not cleared by reset");
   a_dir_byte_wr: assert property (s_dir_wr |=> cpu_ack_ff && pin_oe_n[15:8] == $past(cpu_wdata))
      else $error("direction byte write lost");
   a_elat_wr: assert property (s_elat_wr |=> ext_ack_ff && pin_out[111:104] == ($past(ext_wdata) & 8'h3f))
      else $error("extended latch write lost");
   a_bit_wr_one: assert property (cpu_wr && cpu_bit && cpu_bitsel == 3'h0 && cpu_addr == `PDL_OFS_LAT3
      |=> pin_out[16] == $past(cpu_wdata[0]) && $stable(pin_out[19:17]))
      else $error("bit write wrong");
   a_main_no_ext: assert property (cpu_rd && cpu_addr[15:8] == 8'h00 |=> !cpu_ack_ff && cpu_rdata_ff == 8'h00)
      else $error("extended space visible on main bus");
   a_clkin_zero: assert property (cpu_rd && cpu_addr == `PDL_OFS_LAT2 && &clk_in_mode[15:8]
      |=> cpu_rdata_ff == 8'h00)
      else $error("clock input pin read not zero");
   a_pin_read: assert property (ext_rd && ext_addr == `PDL_OFS_ELAT0 && &pin_oe_n[103:96]
      && clk_in_mode[103:96] == 8'h00
      |=> ext_rdata_ff == ($past(pin_in[103:96]) & 8'h3f))
      else $error("input pin level not read");
   a_latch_read: assert property (ext_rd && ext_addr == `PDL_OFS_ELAT1 && pin_oe_n[109:104] == 6'h00
      && clk_in_mode[111:104] == 8'h00 |=> ext_rdata_ff == {2'b00, $past(pin_out[109:104])})
      else $error("output latch not read");
endmodule

bind pdl_port_bank pdl_port_bank_chk #(.NG(NG)) u_chk (.mclk, .rstn, .cpu_addr, .cpu_wr, .cpu_rd,
   .cpu_bit, .cpu_bitsel, .cpu_wdata, .cpu_rdata_ff, .cpu_ack_ff, .ext_addr, .ext_wr, .ext_rd,
   .ext_wdata, .ext_rdata_ff, .ext_ack_ff, .pin_in, .clk_in_mode, .pin_out, .pin_oe_n);

// ---- sim/pdl_pin_model.sv ----
/*
 Pin model: a wire follows the bank where enabled, else the outside level.
 Assumes active-low enables; fault lets the outside level win on every wire.
*/
module pdl_pin_model #(
   parameter int W = 112
)(
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe_n,
   input  wire logic [W-1:0] ext_lvl,
   input  wire logic         fault,
   output logic      [W-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [W-1:0] rel = pin_oe_n | {W{fault}};
   assign pin_in = (rel & ext_lvl) | (~rel & pin_out);
endmodule

// ---- sim/pdl_port_bank_tb_top.sv ----
/*
 Self-checking bench: reset values, corner accesses and random traffic.
 Assumes the checker and pin model are compiled ahead of it.
*/
`include "pdl_regs.svh"
module pdl_port_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [111:0] DM = `PDL_DIR_MASK;
   localparam logic [111:0] WM = `PDL_LATW_MASK;
   localparam logic [111:0] RM = `PDL_LATR_MASK;
   logic mclk = 1'b0, rstn = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, cpu_bit = 1'b0;
   logic ext_wr = 1'b0, ext_rd = 1'b0, fault = 1'b0, cpu_ack_ff, ext_ack_ff;
   logic [2:0] cpu_bitsel = 3'h0;
   logic [7:0] cpu_wdata = 8'h00, ext_addr = 8'h00, ext_wdata = 8'h00, cpu_rdata_ff, ext_rdata_ff, wd;
   logic [15:0] cpu_addr = 16'h0000;
   logic [111:0] pin_in, pin_out, pin_oe_n, clk_in_mode = '0, ext_lvl = {4{28'h6a5c93e}};
   logic [31:0] seed = 32'h6fd7;
   pdl_pkg::pdl_byte_t dir_e [14], lat_e [14];
   int n_fail = 0, check_count = 0, g;
   pdl_port_bank uut (.mclk, .rstn, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_bit, .cpu_bitsel, .cpu_wdata,
      .cpu_rdata_ff, .cpu_ack_ff, .ext_addr, .ext_wr, .ext_rd, .ext_wdata, .ext_rdata_ff,
      .ext_ack_ff, .pin_in, .clk_in_mode, .pin_out, .pin_oe_n);
   pdl_pin_model #(.W(112)) u_pins (.pin_out, .pin_oe_n, .ext_lvl, .fault, .pin_in);
   initial forever #4 mclk = ~mclk;
   // ==========================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [15:0] adr(input int g, input logic dsel);
      if (g >= 12)
         return {8'h00, 8'h8b + 8'(3 * (g - 12)) + {7'h0, dsel}};
      return {8'hff, 2'b00, dsel, 5'(g < 4 ? g + 1 : g + 4)};
   endfunction
   function automatic logic [7:0] rd_exp(input int g, input logic dsel);
      logic [7:0] d;
      d = dir_e[g];
      if (dsel)
         return d;
      return ((d & ext_lvl[g*8+:8]) | (~d & lat_e[g])) & RM[g*8+:8] & ~clk_in_mode[g*8+:8];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input int g, input logic dsel, wr, bt, input logic [2:0] sel,
                       input logic [7:0] wd);
      logic e;
      logic [7:0] ex, m, nv;
      logic [15:0] a;
      e = g >= 12;
      a = adr(g, dsel);
      ex = rd_exp(g, dsel);
      m = dsel ? DM[g*8+:8] : WM[g*8+:8];
      nv = bt ? ((dsel ? dir_e[g] : lat_e[g]) & ~(8'h1 << sel)) | ({7'h0, wd[0]} << sel) : wd;
      @(negedge mclk);
      {cpu_addr, ext_addr, cpu_bit, cpu_bitsel, cpu_wdata, ext_wdata} = {a, a[7:0], bt, sel, wd, wd};
      {cpu_wr, cpu_rd, ext_wr, ext_rd} = {wr & !e, !wr & !e, wr & e, !wr & e};
      @(negedge mclk);
      chk({7'h0, e ? ext_ack_ff : cpu_ack_ff}, 8'h01);
      if (!wr)
         chk(e ? ext_rdata_ff : cpu_rdata_ff, ex);
      else if (dsel)
         dir_e[g] = (nv & m) | ~m;
      else
         lat_e[g] = nv & m;
      chk(pin_oe_n[g*8+:8], dir_e[g]);
      chk(pin_out[g*8+:8], lat_e[g]);
      {cpu_wr, cpu_rd, ext_wr, ext_rd} = 4'h0;
   endtask
   task automatic nomap(input logic [15:0] a, input logic e);
      @(negedge mclk);
      {cpu_addr, ext_addr, cpu_rd, ext_rd} = {a, a[7:0], !e, e};
      @(negedge mclk);
      chk({6'h0, cpu_ack_ff, ext_ack_ff} | cpu_rdata_ff | ext_rdata_ff, 8'h00);
      {cpu_rd, ext_rd} = 2'b00;
   endtask
   task automatic do_reset();
      @(negedge mclk);
      rstn = 1'b0;
      repeat (5) @(negedge mclk);
      rstn = 1'b1;
      for (int g = 0; g < 14; g++)
      begin
         dir_e[g] = 8'hff;
         lat_e[g] = 8'h00;
         chk(pin_oe_n[g*8+:8], 8'hff);
         chk(pin_out[g*8+:8], 8'h00);
      end
   endtask
   task automatic results();
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      do_reset();
      for (int i = 0; i < 14; i++)
      begin
         xfer(i, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
         xfer(i, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00);
      end
      fault = 1'b1;
      xfer(0, 1'b1, 1'b1, 1'b0, 3'h0, 8'h2e);
      xfer(3, 1'b1, 1'b1, 1'b0, 3'h0, 8'h3f);
      xfer(13, 1'b1, 1'b1, 1'b0, 3'h0, 8'hc0);
      xfer(13, 1'b0, 1'b1, 1'b0, 3'h0, 8'h15);
      xfer(13, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00);
      nomap(16'hff10, 1'b0);
      nomap(16'h008c, 1'b0);
      nomap(16'h008d, 1'b1);
      repeat (1500)
      begin
         seed = xs(seed);
         ext_lvl = {seed, ~seed, seed, seed[23:8]};
         seed = xs(seed);
         clk_in_mode = {112{seed[1:0] == 2'b00}};
         fault = seed[2];
         g = int'(seed[7:4]) % 14;
         wd = seed[21:14];
         // unimplemented direction bits written as 1
         if (seed[8])
            wd = wd | ~DM[g*8+:8] | {7'h0, ~DM[g*8+seed[13:11]]};
         xfer(g, seed[8], seed[9], seed[10] && g < 12, seed[13:11], wd);
      end
      do_reset();
      results();
   end
   // Bound well above about 3100 cycles of traffic
   initial
   begin
      #320us;
      n_fail++;
      results();
   end
endmodule
